// ---- hw/drt_pkg.sv ----
package drt_pkg;

   // Special-function register addresses of the timer.
   localparam logic [7:0] ADDR_CONTROL = 8'hc8;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

   // Bit positions inside the timer control register.
   localparam int BIT_HIGH_FLAG = 7;
   localparam int BIT_LOW_FLAG = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CAPTURE_SRC = 1;
   localparam int BIT_EXT_SEL = 0;

   // Reset values of the registers.
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // Divider figures for the slow count sources.
   localparam int SYSTEM_CLOCK_DIV = 12;
   localparam int OSC_DIV = 8;

   // Special-function register access, one byte per cycle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } drt_sfr_req_t;

   // Clock selects that live in the shared clock select register.
   typedef struct packed {
      logic high_system_clock_select;
      logic low_system_clock_select;
   } drt_clk_sel_t;

endpackage : drt_pkg

// ---- hw/drt_sync_div.sv ----
`timescale 1ns/10ps
// Brings a foreign oscillator into the system clock domain and divides it by eight.
module drt_sync_div #(
   parameter int DIV = drt_pkg::OSC_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic osc_in,
   output logic tick
);

   // Refuse divisors that the eight-bit counter cannot serve.
   if (DIV < 2 || DIV > 256) begin : g_div_check
      $error("drt_sync_div: DIV out of range");
   end

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [7:0] cnt;
      logic tick;
   } drt_sd_state_t;

   drt_sd_state_t st_r;
   drt_sd_state_t st_nxt;

   // Two stages synchronise, the third feeds the rising edge detector.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = osc_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.tick = 1'b0;
      if (st_r.s2 && !st_r.s3) begin // RQ8
         if (st_r.cnt == 8'(DIV - 1)) begin
            st_nxt.cnt = 8'h00;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
         end
      end
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

endmodule : drt_sync_div

// ---- hw/drt_prescale.sv ----
`timescale 1ns/10ps
// Free-running divider that emits a one-cycle enable every DIV system clocks.
module drt_prescale #(
   parameter int DIV = drt_pkg::SYSTEM_CLOCK_DIV
) (
   input wire logic clk,
   input wire logic rst,
   output logic tick
);

   // Refuse divisors that the eight-bit counter cannot serve.
   if (DIV < 2 || DIV > 256) begin : g_div_check
      $error("drt_prescale: DIV out of range");
   end

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } drt_ps_state_t;

   drt_ps_state_t st_r;
   drt_ps_state_t st_nxt;

   // Count and pulse at the wrap.
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt == 8'(DIV - 1)) begin
         st_nxt.cnt = 8'h00;
         st_nxt.tick = 1'b1; // RQ24
      end else begin
         st_nxt.cnt = st_r.cnt + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick = st_r.tick;

endmodule : drt_prescale

// ---- hw/drt_timer.sv ----
`timescale 1ns/10ps
// Function
// RQ1 - Timer is two bytes, split bit selects mode.
// RQ2 - 16-bit rollover reloads and sets high flag.
// RQ3 - 16-bit overflow requests interrupt when enabled.
// RQ4 - Low byte rollover interrupts if low enable.
// RQ5 - Split mode: two bytes reload independently.
// RQ6 - Run gates all, or high byte in split.
// RQ7 - Per-byte clock select in split mode.
// RQ8 - External divided source synchronised before use.
// RQ9 - High and low flags set on rollover.
// RQ10 - Split mode interrupts from either byte.
// RQ11 - Flags cleared only by software writes.
// RQ12 - Four count clock choices from selects.
// RQ13 - Capture every eight source oscillator cycles.
// RQ14 - Capture copies count, sets high flag.
// RQ15 - Software keeps 16-bit mode during capture.
// RQ16 - Capture enable bit turns capture on.
// RQ17 - Capture source also picks external count clock.
// RQ18 - External select: divide-by-12 or named source.
// RQ19 - Software clears low enable in 16-bit mode.
// RQ20 - Control register holds all bits, readable.
// RQ21 - Reload bytes read/write, reset to zero.
// RQ22 - High count byte is read/write register.
// RQ23 - High select only in split mode.
// RQ24 - Single clock, sources become count enables.
// RQ25 - Interrupt is high flag or qualified low.
module drt_timer (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire drt_pkg::drt_sfr_req_t SFR_REQ,
   output logic [7:0] SFR_RDATA,
   input wire drt_pkg::drt_clk_sel_t CLK_SEL,
   input wire logic EXT_OSC,
   input wire logic RTC_OSC,
   output logic IRQ
);

   ////////////////////////////////////////////////////////////////////////////////
   // Count-enable sources, all in the system clock domain.

   logic div12_tick;
   logic ext_tick;
   logic rtc_tick;

   // System clock divided by twelve.
   drt_prescale #(.DIV(drt_pkg::SYSTEM_CLOCK_DIV)) u_div12 (
      .clk(REF_CLK),
      .rst(RST),
      .tick(div12_tick)
   );

   // External oscillator, synchronised and divided by eight.
   drt_sync_div #(.DIV(drt_pkg::OSC_DIV)) u_ext (
      .clk(REF_CLK),
      .rst(RST),
      .osc_in(EXT_OSC),
      .tick(ext_tick)
   );

   // Real-time-clock oscillator, synchronised and divided by eight.
   drt_sync_div #(.DIV(drt_pkg::OSC_DIV)) u_rtc (
      .clk(REF_CLK),
      .rst(RST),
      .osc_in(RTC_OSC),
      .tick(rtc_tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [7:0] control;
      logic [7:0] reload_low_byte;
      logic [7:0] reload_high_byte;
      logic [7:0] count_low_byte;
      logic [7:0] count_high_byte;
      logic [7:0] rdata;
   } drt_state_t;

   drt_state_t st_r;
   drt_state_t st_nxt;

   logic split_mode_enable;
   logic run_bit;
   logic low_byte_irq_enable;
   logic capture_enable;
   logic capture_source_select;
   logic external_select;
   logic alt_tick;
   logic low_en;
   logic high_en;
   logic capture_evt;
   logic low_wrap;
   logic high_wrap;
   logic set_high;
   logic set_low;

   // Field decode of the control register.
   assign split_mode_enable = st_r.control[drt_pkg::BIT_SPLIT]; // RQ1
   assign run_bit = st_r.control[drt_pkg::BIT_RUN];
   assign low_byte_irq_enable = st_r.control[drt_pkg::BIT_LOW_IRQ_EN];
   assign capture_enable = st_r.control[drt_pkg::BIT_CAPTURE_EN];
   assign capture_source_select = st_r.control[drt_pkg::BIT_CAPTURE_SRC];
   assign external_select = st_r.control[drt_pkg::BIT_EXT_SEL];

   ////////////////////////////////////////////////////////////////////////////////
   // Count-enable selection.

   // The non-system choice shared by both bytes.
   always_comb begin
      if (!external_select) begin
         alt_tick = div12_tick; // RQ18
      end else if (capture_source_select) begin
         alt_tick = rtc_tick; // RQ17
      end else begin
         alt_tick = ext_tick; // RQ17
      end
   end

   // Per-byte enables; the high select only counts in split mode.
   always_comb begin
      if (split_mode_enable) begin
         low_en = CLK_SEL.low_system_clock_select ? 1'b1 : alt_tick; // RQ7 RQ6
         high_en = run_bit && (CLK_SEL.high_system_clock_select ? 1'b1 : alt_tick); // RQ6 RQ23
      end else begin
         low_en = run_bit && (CLK_SEL.low_system_clock_select ? 1'b1 : alt_tick); // RQ12 RQ23
         high_en = low_en && (st_r.count_low_byte == 8'hff);
      end
   end

   // Capture fires on every eighth cycle of the opposite oscillator.
   assign capture_evt = capture_enable && (capture_source_select ? ext_tick : rtc_tick); // RQ13 RQ16

   assign low_wrap = low_en && (st_r.count_low_byte == 8'hff);
   assign high_wrap = high_en && (st_r.count_high_byte == 8'hff);
   assign set_low = low_wrap; // RQ9
   assign set_high = high_wrap || capture_evt; // RQ9 RQ14

   ////////////////////////////////////////////////////////////////////////////////
   // Next state: counting, capture, register writes and flag set-over-clear.

   always_comb begin
      st_nxt = st_r;
      // Software writes land first; counting events below override them.
      if (SFR_REQ.wr) begin
         case (SFR_REQ.addr)
            drt_pkg::ADDR_CONTROL: st_nxt.control = SFR_REQ.wdata; // RQ20 RQ11
            drt_pkg::ADDR_RELOAD_LOW: st_nxt.reload_low_byte = SFR_REQ.wdata; // RQ21
            drt_pkg::ADDR_RELOAD_HIGH: st_nxt.reload_high_byte = SFR_REQ.wdata; // RQ21
            drt_pkg::ADDR_COUNT_LOW: st_nxt.count_low_byte = SFR_REQ.wdata;
            drt_pkg::ADDR_COUNT_HIGH: st_nxt.count_high_byte = SFR_REQ.wdata; // RQ22
            default: ;
         endcase
      end
      // Low byte counts or reloads.
      if (low_en) begin
         if (low_wrap && split_mode_enable) begin
            st_nxt.count_low_byte = st_r.reload_low_byte; // RQ5
         end else if (low_wrap && high_wrap) begin
            st_nxt.count_low_byte = st_r.reload_low_byte; // RQ2
         end else begin
            st_nxt.count_low_byte = st_r.count_low_byte + 8'h01;
         end
      end
      // High byte counts or reloads.
      if (high_en) begin
         if (high_wrap) begin
            st_nxt.count_high_byte = st_r.reload_high_byte; // RQ2 RQ5
         end else begin
            st_nxt.count_high_byte = st_r.count_high_byte + 8'h01;
         end
      end
      // Capture copies the live count into the reload pair.
      if (capture_evt) begin
         st_nxt.reload_low_byte = st_r.count_low_byte; // RQ14
         st_nxt.reload_high_byte = st_r.count_high_byte; // RQ14
      end
      // Hardware sets win over a clearing write in the same cycle.
      if (set_high) begin
         st_nxt.control[drt_pkg::BIT_HIGH_FLAG] = 1'b1; // RQ9 RQ11
      end
      if (set_low) begin
         st_nxt.control[drt_pkg::BIT_LOW_FLAG] = 1'b1; // RQ9 RQ11
      end
      // Registered read data, unmapped addresses return zero.
      st_nxt.rdata = 8'h00;
      if (SFR_REQ.rd) begin
         case (SFR_REQ.addr)
            drt_pkg::ADDR_CONTROL: st_nxt.rdata = st_r.control; // RQ20
            drt_pkg::ADDR_RELOAD_LOW: st_nxt.rdata = st_r.reload_low_byte;
            drt_pkg::ADDR_RELOAD_HIGH: st_nxt.rdata = st_r.reload_high_byte;
            drt_pkg::ADDR_COUNT_LOW: st_nxt.rdata = st_r.count_low_byte;
            drt_pkg::ADDR_COUNT_HIGH: st_nxt.rdata = st_r.count_high_byte; // RQ22
            default: st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // State register.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_r.control <= drt_pkg::RESET_CONTROL;
         st_r.reload_low_byte <= drt_pkg::RESET_BYTE;
         st_r.reload_high_byte <= drt_pkg::RESET_BYTE;
         st_r.count_low_byte <= drt_pkg::RESET_BYTE;
         st_r.count_high_byte <= drt_pkg::RESET_BYTE;
         st_r.rdata <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign SFR_RDATA = st_r.rdata;

   // Request is the high flag or the enabled low flag; global masking lies outside.
   assign IRQ = st_r.control[drt_pkg::BIT_HIGH_FLAG] ||
                (st_r.control[drt_pkg::BIT_LOW_FLAG] && low_byte_irq_enable); // RQ3 RQ4 RQ10 RQ25

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // Rollover, flags, stop, capture, interrupt and advance behaviour of the count bytes.
   a_wrap16_reload: assert property ( // RQ2
      (!split_mode_enable && low_wrap && high_wrap && !SFR_REQ.wr) |=>
      ({st_r.count_high_byte, st_r.count_low_byte} ==
       {$past(st_r.reload_high_byte), $past(st_r.reload_low_byte)}))
      else $error("16-bit rollover did not reload");
   a_wrap16_flag: assert property (high_wrap |=> st_r.control[drt_pkg::BIT_HIGH_FLAG]) // RQ9
      else $error("high flag not set on overflow");
   a_low_flag_set: assert property (low_wrap |=> st_r.control[drt_pkg::BIT_LOW_FLAG]) // RQ9
      else $error("low flag not set on rollover");
   a_split_low_reload: assert property ( // RQ5
      (split_mode_enable && low_wrap && !capture_evt && !SFR_REQ.wr) |=>
      st_r.count_low_byte == $past(st_r.reload_low_byte))
      else $error("split low byte did not reload");
   a_split_run_gate: assert property ( // RQ6
      (split_mode_enable && !run_bit && !SFR_REQ.wr) |=> $stable(st_r.count_high_byte))
      else $error("high byte moved while stopped");
   a_stop_holds_count: assert property ( // RQ6
      (!split_mode_enable && !run_bit && !SFR_REQ.wr) |=> $stable(st_r.count_low_byte))
      else $error("count moved while stopped");
   a_capture_copy: assert property ( // RQ14
      capture_evt |=> (st_r.reload_low_byte == $past(st_r.count_low_byte)) &&
      st_r.control[drt_pkg::BIT_HIGH_FLAG])
      else $error("capture did not copy count");
   a_flag_sticky: assert property ( // RQ11
      (st_r.control[drt_pkg::BIT_HIGH_FLAG] && !SFR_REQ.wr) |=>
      st_r.control[drt_pkg::BIT_HIGH_FLAG])
      else $error("high flag cleared by hardware");
   a_low_flag_sticky: assert property ( // RQ11
      (st_r.control[drt_pkg::BIT_LOW_FLAG] && !SFR_REQ.wr) |=>
      st_r.control[drt_pkg::BIT_LOW_FLAG])
      else $error("low flag cleared by hardware");
   a_irq_follows: assert property ( // RQ25
      $rose(st_r.control[drt_pkg::BIT_HIGH_FLAG]) |-> IRQ)
      else $error("interrupt missing for high flag");
   a_system_clock_rate: assert property ( // RQ12
      (!split_mode_enable && run_bit && CLK_SEL.low_system_clock_select && !SFR_REQ.wr &&
       st_r.count_low_byte != 8'hff) |=>
      st_r.count_low_byte == $past(st_r.count_low_byte) + 8'h01)
      else $error("system clock count did not advance");

   // A low wrap without a full overflow is a carry into the high byte.
   a_carry16_step: assert property ( // RQ2
      (!split_mode_enable && low_wrap && !high_wrap && !SFR_REQ.wr) |=>
      (st_r.count_low_byte == 8'h00) &&
      (st_r.count_high_byte == $past(st_r.count_high_byte) + 8'h01))
      else $error("16-bit carry did not step the high byte");
   // Outside split mode the high select must not move the high byte by itself.
   a_high_follows_low: assert property ( // RQ23
      (!split_mode_enable && !low_wrap && !SFR_REQ.wr) |=> $stable(st_r.count_high_byte))
      else $error("high byte moved without a carry");

   // Split mode: the low byte runs free, the high byte follows run and its select.
   a_split_low_free: assert property ( // RQ6
      (split_mode_enable && !run_bit && CLK_SEL.low_system_clock_select && !SFR_REQ.wr &&
       st_r.count_low_byte != 8'hff) |=>
      st_r.count_low_byte == $past(st_r.count_low_byte) + 8'h01)
      else $error("split low byte stopped with run clear");
   a_split_high_sys: assert property ( // RQ7
      (split_mode_enable && run_bit && CLK_SEL.high_system_clock_select && !SFR_REQ.wr &&
       st_r.count_high_byte != 8'hff) |=>
      st_r.count_high_byte == $past(st_r.count_high_byte) + 8'h01)
      else $error("split high byte did not follow its select");
   a_split_high_reload: assert property ( // RQ5
      (split_mode_enable && high_wrap && !SFR_REQ.wr) |=>
      st_r.count_high_byte == $past(st_r.reload_high_byte))
      else $error("split high byte did not reload");

   // Capture copies the high byte too, and leaves the reload pair alone when off.
   a_capture_high: assert property ( // RQ14
      capture_evt |=> st_r.reload_high_byte == $past(st_r.count_high_byte))
      else $error("capture did not copy the high byte");
   a_capture_gated: assert property ( // RQ16
      (!capture_enable && !SFR_REQ.wr) |=>
      $stable(st_r.reload_low_byte) && $stable(st_r.reload_high_byte))
      else $error("reload changed with capture disabled");

   // Count enables are single-cycle pulses; the prescaler recurs at its period.
   localparam int TICK_GAP = drt_pkg::SYSTEM_CLOCK_DIV;
   a_div12_period: assert property (div12_tick |-> ##TICK_GAP div12_tick) // RQ12 RQ18
      else $error("prescaler period wrong");
   a_div12_single: assert property (div12_tick |=> !div12_tick) // RQ24
      else $error("prescaler enable longer than one cycle");
   a_ext_single: assert property (ext_tick |=> !ext_tick) // RQ8 RQ24
      else $error("external enable longer than one cycle");
   a_rtc_single: assert property (rtc_tick |=> !rtc_tick) // RQ24
      else $error("slow oscillator enable longer than one cycle");

   // Slow sources advance the 16-bit count only on their enable pulse.
   a_div12_gate: assert property ( // RQ18
      (!split_mode_enable && !CLK_SEL.low_system_clock_select && !external_select &&
       !div12_tick && !SFR_REQ.wr) |=> $stable(st_r.count_low_byte))
      else $error("count moved between prescaler pulses");
   a_ext_gate: assert property ( // RQ17
      (!split_mode_enable && !CLK_SEL.low_system_clock_select && external_select &&
       !capture_source_select && !ext_tick && !SFR_REQ.wr) |=>
      $stable(st_r.count_low_byte))
      else $error("count moved between external pulses");

   // Register writes land unless hardware claims the same bits in that cycle.
   a_control_write: assert property ( // RQ20
      (SFR_REQ.wr && SFR_REQ.addr == drt_pkg::ADDR_CONTROL && !set_high && !set_low) |=>
      st_r.control == $past(SFR_REQ.wdata))
      else $error("control write lost");
   a_reload_write: assert property ( // RQ21
      (SFR_REQ.wr && SFR_REQ.addr == drt_pkg::ADDR_RELOAD_HIGH && !capture_evt) |=>
      st_r.reload_high_byte == $past(SFR_REQ.wdata))
      else $error("reload high write lost");

   // Read data stands one cycle after the strobe and is zero otherwise.
   a_read_count_high: assert property ( // RQ22
      (SFR_REQ.rd && SFR_REQ.addr == drt_pkg::ADDR_COUNT_HIGH) |=>
      SFR_RDATA == $past(st_r.count_high_byte))
      else $error("count high read wrong");
   a_read_idle: assert property (!SFR_REQ.rd |=> SFR_RDATA == 8'h00) // RQ20
      else $error("read data not cleared");

   // The low flag requests only with its enable set.
   a_irq_low_gate: assert property ( // RQ4 RQ10
      (!st_r.control[drt_pkg::BIT_HIGH_FLAG] && !low_byte_irq_enable) |-> !IRQ)
      else $error("low flag requested while masked");
   a_irq_low_on: assert property ( // RQ4 RQ10
      (st_r.control[drt_pkg::BIT_LOW_FLAG] && low_byte_irq_enable) |-> IRQ)
      else $error("low flag request missing");

   // Main scenarios that the bench should reach.
   c_wrap16: cover property (!split_mode_enable && high_wrap);
   c_split_low: cover property (split_mode_enable && low_wrap);
   c_split_high: cover property (split_mode_enable && high_wrap);
   c_capture: cover property (capture_evt);
   c_low_irq: cover property (IRQ && low_byte_irq_enable);

endmodule : drt_timer

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   logic ref_clk;
   logic rst;
   logic ext_osc;
   logic rtc_osc;
   logic irq;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [15:0] lfsr;
   drt_pkg::drt_sfr_req_t req;
   drt_pkg::drt_clk_sel_t csel;
   int n_mismatch;
   int check_count;
   // Every mapped place, used for the reset checks.
   logic [7:0] u_addr [5] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};

   drt_timer u_dut (
      .REF_CLK(ref_clk),
      .RST(rst),
      .SFR_REQ(req),
      .SFR_RDATA(rdata),
      .CLK_SEL(csel),
      .EXT_OSC(ext_osc),
      .RTC_OSC(rtc_osc),
      .IRQ(irq)
   );

   ////////////////////////////////////////////////////////////////////////
   // Free-running system clock of 4 ns.
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Next random value; the seed is fixed so every run repeats.
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   ////////////////////////////////////////////////////////////////////////
   // One register write, held across exactly one sampling edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      req = '0;
   endtask : wr

   // One register read; the data stands for the cycle after the strobe.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #1;
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      #1;
      d = rdata;
      req = '0;
   endtask : rd

   // Compares one byte and counts the outcome.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Reads a register and compares it.
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp, what);
   endtask : chk_rd

   // Toggles one oscillator n times, three system clocks per half period.
   task automatic osc(input bit ext, input int n);
      repeat (n) begin
         repeat (3) @(posedge ref_clk);
         #1;
         if (ext) ext_osc = ~ext_osc;
         else rtc_osc = ~rtc_osc;
      end
   endtask : osc

   // Prints the counts and the verdict, then stops.
   task automatic end_sim;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////
   // Cuts a hang short.
   initial begin
      #200000;
      n_mismatch++;
      end_sim;
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      req = '0;
      csel = '0;
      ext_osc = 1'b0;
      rtc_osc = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      lfsr = 16'h0002;
      repeat (8) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      // Reset values of every register, and an idle request line.
      foreach (u_addr[i]) chk_rd(u_addr[i], 8'h00, "reset");
      chk({7'h00, irq}, 8'h00, "irq reset");
      // Read data falls back to zero one cycle after the last read.
      @(posedge ref_clk);
      #1;
      chk(rdata, 8'h00, "rdata idle");
      // Unmapped place ignores writes and reads zero.
      wr(8'hc9, 8'h5a);
      chk_rd(8'hc9, 8'h00, "unmapped");
      // Random read-back of the byte registers while stopped.
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(8'hca, lfsr[7:0]);
         wr(8'hcb, lfsr[15:8]);
         wr(8'hcd, lfsr[7:0] ^ lfsr[15:8]);
         chk_rd(8'hca, lfsr[7:0], "reload low");
         chk_rd(8'hcb, lfsr[15:8], "reload high");
         chk_rd(8'hcd, lfsr[7:0] ^ lfsr[15:8], "count high");
      end
      wr(8'hc8, 8'h33);
      chk_rd(8'hc8, 8'h33, "control rw");
      // Full 16-bit rollover on the system clock reloads and flags.
      wr(8'hca, 8'h00);
      wr(8'hcb, 8'hab);
      wr(8'hcc, 8'hfd);
      wr(8'hcd, 8'hff);
      csel = '{high_system_clock_select: 1'b0, low_system_clock_select: 1'b1};
      wr(8'hc8, 8'h04);
      repeat (10) @(posedge ref_clk);
      chk_rd(8'hc8, 8'hc4, "both flags");
      chk({7'h00, irq}, 8'h01, "irq overflow");
      wr(8'hc8, 8'hc0);
      chk_rd(8'hcd, 8'hab, "reloaded high");
      repeat (50) @(posedge ref_clk);
      chk_rd(8'hc8, 8'hc0, "flags stay");
      wr(8'hc8, 8'h40);
      chk({7'h00, irq}, 8'h00, "low masked");
      wr(8'hc8, 8'h60);
      chk({7'h00, irq}, 8'h01, "low enabled");
      // Divide-by-12 count source in 16-bit mode.
      wr(8'hc8, 8'h00);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      // The high select must be ignored outside split mode.
      csel = '{high_system_clock_select: 1'b1, low_system_clock_select: 1'b0};
      wr(8'hc8, 8'h04);
      repeat (120) @(posedge ref_clk);
      wr(8'hc8, 8'h00);
      rd(8'hcc, v);
      chk(8'(v >= 8'd9 && v <= 8'd11), 8'h01, "div12");
      // External and slow-oscillator sources divided by eight.
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h05);
      osc(1'b1, 32);
      repeat (10) @(posedge ref_clk);
      chk_rd(8'hcc, 8'h02, "ext div8");
      wr(8'hc8, 8'h00);
      wr(8'hcc, 8'h00);
      wr(8'hc8, 8'h07);
      osc(1'b0, 32);
      repeat (10) @(posedge ref_clk);
      chk_rd(8'hcc, 8'h02, "rtc div8");
      // Split mode: low byte runs while stopped, high byte holds.
      wr(8'hc8, 8'h00);
      wr(8'hca, 8'hf0);
      wr(8'hcb, 8'h20);
      wr(8'hcd, 8'h55);
      csel = '{high_system_clock_select: 1'b0, low_system_clock_select: 1'b1};
      wr(8'hc8, 8'h08);
      repeat (300) @(posedge ref_clk);
      chk_rd(8'hcd, 8'h55, "high held");
      chk_rd(8'hc8, 8'h48, "low flag only");
      chk({7'h00, irq}, 8'h00, "split low masked");
      rd(8'hcc, v);
      chk({7'h00, v[7:4] == 4'hf}, 8'h01, "low reload");
      wr(8'hc8, 8'h68);
      chk({7'h00, irq}, 8'h01, "split low irq");
      // Split mode high byte on the system clock with run set.
      wr(8'hc8, 8'h08);
      wr(8'hcd, 8'hfe);
      csel = '{high_system_clock_select: 1'b1, low_system_clock_select: 1'b1};
      wr(8'hc8, 8'h0c);
      repeat (6) @(posedge ref_clk);
      rd(8'hc8, v);
      chk({7'h00, v[7]}, 8'h01, "high flag split");
      wr(8'hc8, 8'h08);
      rd(8'hcd, v);
      chk({7'h00, v[7:4] == 4'h2}, 8'h01, "high reload");
      // Capture every eight slow-oscillator cycles, then disabled.
      wr(8'hc8, 8'h00);
      wr(8'hca, 8'h00);
      wr(8'hcb, 8'h00);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      csel = '{high_system_clock_select: 1'b0, low_system_clock_select: 1'b1};
      wr(8'hc8, 8'h14);
      osc(1'b0, 16);
      repeat (10) @(posedge ref_clk);
      chk_rd(8'hc8, 8'h94, "capture flag");
      rd(8'hca, v);
      chk({7'h00, v != 8'h00}, 8'h01, "captured count");
      wr(8'hc8, 8'h04);
      osc(1'b0, 16);
      repeat (10) @(posedge ref_clk);
      chk_rd(8'hc8, 8'h04, "capture off");
      // A second reset in mid-run returns every register to zero.
      @(posedge ref_clk);
      #1;
      rst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      foreach (u_addr[i]) chk_rd(u_addr[i], 8'h00, "second reset");
      end_sim;
   end
endmodule : testbench
